// File: bench/b_pin_model.sv
// Sensed signal on the B pins: square wave while running, low otherwise
`timescale 1ns/100ps
module b_pin_model #(
    parameter int HALF = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control and pins
    input wire logic run,
    output logic [7:0] pin_b_in
);
    int ph;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph <= 0;
            pin_b_in <= 8'h00;
        end else begin
            ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
            pin_b_in <= (run && ph < HALF) ? 8'hff : 8'h00;
        end
    end
endmodule : b_pin_model

// File: bench/pwm_props.sv
// Port-level assertions for the PWM slice bank
`timescale 1ns/100ps
module pwm_props #(
    parameter int N_SLICES = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and events
    input wire logic [N_SLICES-1:0] pin_b_in,
    input wire logic [N_SLICES-1:0] out_a,
    input wire logic [N_SLICES-1:0] out_b,
    input wire logic [1:0] irq_wrap,
    input wire logic [N_SLICES-1:0] dma_req
);
    logic en3_reg;
    logic [7:0] ie0_reg, if0_reg, ie1_reg, if1_reg;
    wire logic wr_hit = psel && penable && pwrite && pready;
    wire logic wr_csr3 = wr_hit && paddr == 12'h060;
    // Shadow copies of the few registers the assertions depend on
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            en3_reg <= 1'b0;
            ie0_reg <= 8'h00;
            if0_reg <= 8'h00;
            ie1_reg <= 8'h00;
            if1_reg <= 8'h00;
        end else if (wr_hit) begin
            if (paddr == 12'h060) en3_reg <= pwdata[0];
            if (paddr == 12'h104) ie0_reg <= pwdata[7:0];
            if (paddr == 12'h108) if0_reg <= pwdata[7:0];
            if (paddr == 12'h110) ie1_reg <= pwdata[7:0];
            if (paddr == 12'h114) if1_reg <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    AST_READY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    AST_UNMAP_ZERO: assert property (psel && penable && !pwrite && pslverr |-> prdata == 0)
        else $error("refused read returned data");
    AST_UNALIGN_ERR: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access not refused");
    AST_MAPPED_OK: assert property (psel && penable && paddr[11:8] == 4'h0
        && paddr[4:2] < 3'h5 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("slice register refused");
    AST_RESET_QUIET: assert property ($rose(arst_n) |-> irq_wrap == 2'b00 && dma_req == 0)
        else $error("event outputs not quiet after reset");
    AST_HOLD_OFF: assert property (!en3_reg && !wr_csr3 && !$past(wr_csr3)
        |=> $stable(out_a[3]) && $stable(out_b[3]))
        else $error("disabled slice outputs moved");
    AST_FORCE0: assert property (|(ie0_reg & if0_reg) |=> irq_wrap[0])
        else $error("forced line 0 not raised");
    AST_FORCE1: assert property (|(ie1_reg & if1_reg) |=> irq_wrap[1])
        else $error("forced line 1 not raised");
    AST_MASK0: assert property (ie0_reg == 8'h00 |=> !irq_wrap[0])
        else $error("line 0 raised with empty mask");
    cover property (irq_wrap[0]);
    cover property (dma_req[3]);
    cover property (psel && penable && pslverr);
endmodule : pwm_props

// File: bench/testbench.sv
// Self-checking bench for the PWM slice bank
`timescale 1ns/100ps
module testbench;
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, b_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] pin_b_in, out_a, out_b, dma_req;
    logic [1:0] irq_wrap;
    logic [31:0] exp_q[$];
    logic [15:0] seed;
    int n_mismatch, compares, cyc, i;
    int mode_exp[4] = '{12, 6, 2, 2};
    pwm_slice_counter_divider pwm_slice_counter_divider_inst (.core_clk(core_clk),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_b_in(pin_b_in), .out_a(out_a), .out_b(out_b), .irq_wrap(irq_wrap),
        .dma_req(dma_req));
    b_pin_model b_pin_model_inst (.core_clk(core_clk), .arst_n(arst_n), .run(b_run),
        .pin_b_in(pin_b_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic conclude;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    // Counts over 48 cycles so any period dividing it gives an exact figure
    task automatic meas(input int ea, input int eb, input int ed);
        logic [31:0] ca, cb, cd;
        ca = '0;
        cb = '0;
        cd = '0;
        repeat (30) @(posedge core_clk);
        repeat (48) begin
            @(posedge core_clk);
            ca = ca + out_a[3];
            cb = cb + out_b[3];
            cd = cd + dma_req[3];
        end
        if (ea >= 0) chk("out_a high", 32'(ea), ca);
        if (eb >= 0) chk("out_b high", 32'(eb), cb);
        chk("dma pulses", 32'(ed), cd);
    endtask : meas
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            chk($sformatf("prdata %h", paddr), exp_q.pop_front(), prdata);
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        b_run = 1'b0;
        seed = 16'h003c;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(12'h060, 32'h0000_0000);
        rd(12'h064, 32'h0000_0010);
        rd(12'h070, 32'h0000_ffff);
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(12'(i * 32 + 16), {16'h0000, seed});
            rd(12'(i * 32 + 16), {16'h0000, seed});
        end
        wr(12'h070, 32'h0000_0003);
        wr(12'h06c, 32'h0003_0001);
        wr(12'h068, 32'h0000_0000);
        wr(12'h060, 32'h0000_0001);
        meas(12, 36, 12);
        wr(12'h060, 32'h0000_0005);
        meas(36, 36, 12);
        wr(12'h060, 32'h0000_0003);
        meas(12, 36, 6);
        wr(12'h060, 32'h0000_0001);
        wr(12'h064, 32'h0000_0020);
        meas(12, 36, 6);
        wr(12'h064, 32'h0000_0018);
        meas(-1, -1, 8);
        wr(12'h064, 32'h0000_0010);
        b_run <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(12'h060, 32'(1 + i * 16));
            meas(-1, -1, mode_exp[i]);
        end
        b_run <= 1'b0;
        wr(12'h060, 32'h0000_0000);
        wr(12'h068, 32'h0000_0001);
        wr(12'h060, 32'h0000_0040);
        rd(12'h068, 32'h0000_0002);
        rd(12'h060, 32'h0000_0000);
        wr(12'h0b0, 32'h0000_0000);
        wr(12'h0a0, 32'h0000_0001);
        wr(12'h0a0, 32'h0000_0000);
        rd(12'h100, 32'h0000_0028);
        wr(12'h100, 32'h0000_0008);
        rd(12'h100, 32'h0000_0020);
        wr(12'h104, 32'h0000_0028);
        wr(12'h108, 32'h0000_0008);
        rd(12'h10c, 32'h0000_0028);
        wr(12'h108, 32'h0000_0080);
        rd(12'h10c, 32'h0000_0020);
        wr(12'h110, 32'h0000_0001);
        wr(12'h114, 32'h0000_0001);
        rd(12'h118, 32'h0000_0001);
        chk("irq_wrap", 32'h0000_0003, {30'h0000_0000, irq_wrap});
        rd(12'h0fc, 32'h0000_0000);
        rd(12'h002, 32'h0000_0000);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(12'h070, 32'h0000_ffff);
        rd(12'h100, 32'h0000_0000);
        @(posedge core_clk);
        chk("reads left", 32'h0000_0000, 32'(exp_q.size()));
        conclude();
    end
endmodule : testbench
bind pwm_slice_counter_divider pwm_props #(.N_SLICES(N_SLICES)) pwm_props_inst (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_b_in(pin_b_in), .out_a(out_a), .out_b(out_b),
    .irq_wrap(irq_wrap), .dma_req(dma_req));

// File: hdl/pwm_slice_counter_divider.sv
// Bank of PWM slices with fractional dividers, wrap interrupts and an APB register slave
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "pwm_consts.svh"

// Summary of operation
// - Free-running mode: divider paces the counter continuously, B pin ignored.
// - Level mode: divider runs only while the B input is high.
// - Rising mode: divider takes one step per rising edge of B.
// - Falling mode: divider takes one step per falling edge of B.
// - Mode codes: 0 free, 1 B level, 2 B rising, 3 B falling.
// - Phase advance moves counter forward one count; bit reads back until done.
// - Free-running counter rate is system clock over the divide value.
// - Gated and edge modes divide qualifying B events by the divide value.
// - Divider is unsigned fixed point: eight integer, four fraction bits.
// - Divider mode resets to free-running.
// - Separate inversion controls for outputs A and B.
// - Phase-correct counter reverses at top; otherwise it wraps to zero.
// - Phase-correct period is twice the wrapping period.
// - Counter counts up to top inclusive then returns to zero.
// - Reset configuration: free-running, divide one, no phase correct, top 0xffff.
// - Counter value is readable at any time.
// - Software clears one slice's pending flag without touching others.
// - Software forces a slice interrupt on a chosen line.
// - Two wrap interrupt lines, each with enable mask and readable status.
// - Raw status read gives one set bit per pending slice.
// - Slice n sits at bit n of every slice mask.
// - Eight slices, each with outputs A and B.
// - Each slice raises its own DMA pacing request.
// - Output deasserts once counter reaches compare, asserted below it.
// - Compare writes buffered to wrap or zero while running, immediate when stopped.
// - Disabled slice halts counter and holds outputs, except that a manual advance still steps both; re-enable resumes.
module pwm_slice_counter_divider #(
    parameter int N_SLICES = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [N_SLICES-1:0] pin_b_in,
    output logic [N_SLICES-1:0] out_a,
    output logic [N_SLICES-1:0] out_b,
    // Interrupt lines and DMA pacing
    output logic [1:0] irq_wrap,
    output logic [N_SLICES-1:0] dma_req
);
    localparam int SL_W = $clog2(N_SLICES);

    // One counter step; phase-correct dwells once at top and once at zero
    function automatic pwm_pkg::step_s step_f(input pwm_pkg::step_s cur,
                                              input logic [15:0] top,
                                              input logic pc);
        pwm_pkg::step_s r;
        r = cur;
        r.wrap = 1'b0;
        if (!pc) begin
            if (cur.cnt == top) begin
                r.cnt = 16'h0000;
                r.wrap = 1'b1;
            end else begin
                r.cnt = cur.cnt + 16'h0001;
            end
        end else if (!cur.down) begin
            if (cur.cnt == top) begin
                r.down = 1'b1;
            end else begin
                r.cnt = cur.cnt + 16'h0001;
            end
        end else begin
            if (cur.cnt == 16'h0000) begin
                r.down = 1'b0;
                r.wrap = 1'b1;
            end else begin
                r.cnt = cur.cnt - 16'h0001;
            end
        end
        return r;
    endfunction : step_f

    // Bus decode
    wire setup_w = psel & ~penable;
    wire wr_w = psel & penable & pwrite;
    wire glb_w = paddr[`PWM_GLB_BIT];
    wire [2:0] idx_w = paddr[`PWM_IDX_MSB:`PWM_IDX_LSB];
    wire [SL_W-1:0] sl_w = paddr[`PWM_SL_LSB +: SL_W];
    // Upper address bits must be clear, so aliased addresses are refused
    wire hi_zero_w = (paddr[`PWM_TOP_MSB:`PWM_TOP_LSB] == 3'h0) && (paddr[1:0] == 2'h0);
    wire sl_ok_w = ({1'b0, sl_w} < (SL_W + 1)'(N_SLICES)) && (idx_w <= `PWM_TOP_IDX);
    wire glb_ok_w = (idx_w <= `PWM_INTS1_IDX);
    wire map_ok_w = hi_zero_w && (glb_w ? glb_ok_w : sl_ok_w);
    wire glb_wr_w = wr_w && hi_zero_w && glb_w;

    logic [N_SLICES-1:0] intr_reg;
    logic [N_SLICES-1:0] inte0_reg;
    logic [N_SLICES-1:0] inte1_reg;
    logic [N_SLICES-1:0] intf0_reg;
    logic [N_SLICES-1:0] intf1_reg;
    logic [N_SLICES-1:0] wrap_w;
    logic [31:0] sl_rd_w [N_SLICES];
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [1:0] irq_reg;
    logic [N_SLICES-1:0] dreq_reg;

    genvar gi;
    generate
        for (gi = 0; gi < N_SLICES; gi++) begin : g_sl
            pwm_pkg::slice_cfg_s cfg_reg;
            logic adv_reg;
            logic [11:0] div_reg;
            logic [12:0] acc_reg;
            logic [12:0] acc_next;
            logic [15:0] top_reg;
            pwm_pkg::step_s st_reg, st_next;
            pwm_pkg::step_s s1, s2;
            pwm_pkg::cmp_s cc_shadow_reg;
            pwm_pkg::cmp_s cc_live_reg;
            pwm_pkg::cmp_s cc_shadow_next;
            logic b_prev_reg;
            logic a_reg;
            logic bo_reg;
            logic qual;
            logic tick;
            logic do_step;
            logic [12:0] acc_sum;

            wire hit_w = wr_w && hi_zero_w && !glb_w && (sl_w == SL_W'(gi));
            wire wr_csr = hit_w && (idx_w == `PWM_CSR_IDX);
            wire wr_div = hit_w && (idx_w == `PWM_DIV_IDX);
            wire wr_ctr = hit_w && (idx_w == `PWM_CTR_IDX);
            wire wr_cc = hit_w && (idx_w == `PWM_CC_IDX);
            wire wr_top = hit_w && (idx_w == `PWM_TOP_IDX);
            wire b_w = pin_b_in[gi];

            // Event qualification by divider mode
            always_comb begin
                case (cfg_reg.mode)
                    pwm_pkg::DIV_FREE: qual = 1'b1;
                    pwm_pkg::DIV_B_LEVEL: qual = b_w;
                    pwm_pkg::DIV_B_RISE: qual = b_w & ~b_prev_reg;
                    pwm_pkg::DIV_B_FALL: qual = ~b_w & b_prev_reg;
                    default: qual = 1'b0;
                endcase
            end

            // Fractional divider: add one whole-unit step (sixteen sixteenths), emit on reaching the divide value
            assign acc_sum = acc_reg + `PWM_DIV_ONE;
            always_comb begin
                tick = 1'b0;
                acc_next = acc_reg;
                if (cfg_reg.en && qual) begin
                    if (acc_sum >= {1'b0, div_reg}) begin
                        tick = 1'b1;
                        acc_next = acc_sum - {1'b0, div_reg};
                    end else begin
                        acc_next = acc_sum;
                    end
                end
            end

            // Advance and divider step can coincide; apply both so no count is lost
            assign s1 = step_f(st_reg, top_reg, cfg_reg.phase_corr);
            assign s2 = step_f(s1, top_reg, cfg_reg.phase_corr);
            always_comb begin
                st_next = st_reg;
                st_next.wrap = 1'b0;
                if (tick && adv_reg) begin
                    st_next = s2;
                    st_next.wrap = s1.wrap | s2.wrap;
                end else if (tick || adv_reg) begin
                    st_next = s1;
                end
            end
            assign do_step = tick | adv_reg;

            assign cc_shadow_next = wr_cc ? pwdata : cc_shadow_reg;
            // Live compare follows the shadow at each wrap, or at once while stopped
            wire cc_load_w = !cfg_reg.en || st_next.wrap;
            // Pins follow the next count so they change on the same edge as the counter
            wire a_next = (st_next.cnt < cc_live_reg.a) ^ cfg_reg.inv_a;
            wire bo_next = (st_next.cnt < cc_live_reg.b) ^ cfg_reg.inv_b;
            wire pin_upd_w = cfg_reg.en || do_step;

            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    cfg_reg <= `PWM_CFG_RST;
                    div_reg <= `PWM_DIV_RST;
                    top_reg <= `PWM_TOP_RST;
                    adv_reg <= 1'b0;
                    acc_reg <= '0;
                    // Starts low like the idle pin, so leaving reset shows no false edge
                    b_prev_reg <= 1'b0;
                end else begin
                    if (wr_csr) begin
                        cfg_reg <= pwdata[`PWM_CFG_MSB:0];
                    end
                    if (wr_div) begin
                        div_reg <= pwdata[`PWM_DIV_MSB:0];
                    end
                    if (wr_top) begin
                        top_reg <= pwdata[15:0];
                    end
                    adv_reg <= wr_csr & pwdata[`PWM_ADV_BIT];
                    // A new divide value restarts the fraction; no old remainder carries over
                    acc_reg <= wr_div ? 13'h0000 : acc_next;
                    b_prev_reg <= b_w;
                end
            end

            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    st_reg <= '0;
                    cc_shadow_reg <= '0;
                    cc_live_reg <= '0;
                end else begin
                    st_reg <= st_next;
                    if (wr_ctr) begin
                        st_reg.cnt <= pwdata[15:0];
                    end
                    cc_shadow_reg <= cc_shadow_next;
                    if (cc_load_w) begin
                        cc_live_reg <= cc_shadow_next;
                    end
                end
            end

            // Halted slice keeps its pins; a manual advance still moves them
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    a_reg <= 1'b0;
                    bo_reg <= 1'b0;
                end else if (pin_upd_w) begin
                    a_reg <= a_next;
                    bo_reg <= bo_next;
                end
            end

            assign out_a[gi] = a_reg;
            assign out_b[gi] = bo_reg;
            // Taken from the next state so flag and pacing pulse land with count zero
            assign wrap_w[gi] = st_next.wrap;

            always_comb begin
                case (idx_w)
                    `PWM_CSR_IDX: sl_rd_w[gi] = {25'h000_0000, adv_reg, cfg_reg};
                    `PWM_DIV_IDX: sl_rd_w[gi] = {20'h0_0000, div_reg};
                    `PWM_CTR_IDX: sl_rd_w[gi] = {16'h0000, st_reg.cnt};
                    `PWM_CC_IDX: sl_rd_w[gi] = cc_shadow_reg;
                    `PWM_TOP_IDX: sl_rd_w[gi] = {16'h0000, top_reg};
                    default: sl_rd_w[gi] = 32'h0000_0000;
                endcase
            end
        end
    endgenerate

    // Global write strobes
    wire wr_intr_w = glb_wr_w && (idx_w == `PWM_INTR_IDX);
    wire wr_inte0_w = glb_wr_w && (idx_w == `PWM_INTE0_IDX);
    wire wr_inte1_w = glb_wr_w && (idx_w == `PWM_INTE1_IDX);
    wire wr_intf0_w = glb_wr_w && (idx_w == `PWM_INTF0_IDX);
    wire wr_intf1_w = glb_wr_w && (idx_w == `PWM_INTF1_IDX);

    // Interrupt flags: a wrap in the clearing cycle survives
    wire [N_SLICES-1:0] clr_w = wr_intr_w ? pwdata[N_SLICES-1:0] : '0;
    wire [N_SLICES-1:0] ints0_w = (intr_reg | intf0_reg) & inte0_reg;
    wire [N_SLICES-1:0] ints1_w = (intr_reg | intf1_reg) & inte1_reg;
    wire [1:0] irq_next = {|ints1_w, |ints0_w};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            intr_reg <= '0;
            inte0_reg <= '0;
            inte1_reg <= '0;
            intf0_reg <= '0;
            intf1_reg <= '0;
        end else begin
            intr_reg <= (intr_reg & ~clr_w) | wrap_w;
            if (wr_inte0_w) begin
                inte0_reg <= pwdata[N_SLICES-1:0];
            end
            if (wr_inte1_w) begin
                inte1_reg <= pwdata[N_SLICES-1:0];
            end
            // Force bits are plain levels that stay until software writes zero
            if (wr_intf0_w) begin
                intf0_reg <= pwdata[N_SLICES-1:0];
            end
            if (wr_intf1_w) begin
                intf1_reg <= pwdata[N_SLICES-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 2'b00;
            dreq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
            dreq_reg <= wrap_w;
        end
    end

    logic [N_SLICES-1:0] glb_rd_w;
    always_comb begin
        case (idx_w)
            `PWM_INTR_IDX: glb_rd_w = intr_reg;
            `PWM_INTE0_IDX: glb_rd_w = inte0_reg;
            `PWM_INTF0_IDX: glb_rd_w = intf0_reg;
            `PWM_INTS0_IDX: glb_rd_w = ints0_w;
            `PWM_INTE1_IDX: glb_rd_w = inte1_reg;
            `PWM_INTF1_IDX: glb_rd_w = intf1_reg;
            `PWM_INTS1_IDX: glb_rd_w = ints1_w;
            default: glb_rd_w = '0;
        endcase
    end

    wire [31:0] rd_sel_w = !map_ok_w ? 32'h0000_0000 :
                           glb_w ? 32'(glb_rd_w) : sl_rd_w[sl_w];

    // Read data is captured in the setup cycle so the access phase needs no wait
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_w) begin
            prdata_reg <= rd_sel_w;
            pslverr_reg <= ~map_ok_w;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    // Every access phase completes in one cycle, so the slave never stalls the master
    assign pready = 1'b1;
    assign irq_wrap = irq_reg;
    assign dma_req = dreq_reg;
endmodule : pwm_slice_counter_divider

// File: include/pwm_consts.svh
// Register offsets, field positions and reset values for the PWM slice bank
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH
// Byte address layout: bit 8 picks the global page, bits 7:5 the slice, bits 4:2 the word
`define PWM_GLB_BIT 8
`define PWM_SL_LSB 5
`define PWM_IDX_MSB 4
`define PWM_IDX_LSB 2
`define PWM_TOP_MSB 11
`define PWM_TOP_LSB 9
// Slice word indices
`define PWM_CSR_IDX 3'h0
`define PWM_DIV_IDX 3'h1
`define PWM_CTR_IDX 3'h2
`define PWM_CC_IDX 3'h3
`define PWM_TOP_IDX 3'h4
// Global word indices
`define PWM_INTR_IDX 3'h0
`define PWM_INTE0_IDX 3'h1
`define PWM_INTF0_IDX 3'h2
`define PWM_INTS0_IDX 3'h3
`define PWM_INTE1_IDX 3'h4
`define PWM_INTF1_IDX 3'h5
`define PWM_INTS1_IDX 3'h6
// Control word fields
`define PWM_CFG_MSB 5
`define PWM_ADV_BIT 6
`define PWM_DIV_MSB 11
// Reset values and fixed figures
`define PWM_TOP_RST 16'hffff
`define PWM_DIV_RST 12'h010
`define PWM_DIV_ONE 13'h0010
`define PWM_CFG_RST 6'h00
`endif

// File: include/pwm_pkg.sv
// Types shared by the PWM slice bank
package pwm_pkg;
    typedef enum logic [1:0] {
        DIV_FREE = 2'b00,
        DIV_B_LEVEL = 2'b01,
        DIV_B_RISE = 2'b10,
        DIV_B_FALL = 2'b11
    } div_mode_e;
    typedef struct packed {
        div_mode_e mode;
        logic inv_b;
        logic inv_a;
        logic phase_corr;
        logic en;
    } slice_cfg_s;
    typedef struct packed {
        logic [15:0] b;
        logic [15:0] a;
    } cmp_s;
    typedef struct packed {
        logic wrap;
        logic down;
        logic [15:0] cnt;
    } step_s;
endpackage : pwm_pkg
